// ### lpm_pkg.sv
/*
  Constants, register map and carrier types of the low-power mode sequencer.
  Assumes a 25 MHz APB clock and 32-bit APB data with word-aligned registers.
*/
`default_nettype none
package lpm_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_STBY_CTRL = 8'h00; // standby_control_reg
  localparam logic [7:0] OFS_DEEP_CTRL = 8'h04; // deep_standby_control_reg
  localparam logic [7:0] OFS_MSTP_A = 8'h08; // module_stop_ctrl_a
  localparam logic [7:0] OFS_MSTP_B = 8'h0c; // module_stop_ctrl_b
  localparam logic [7:0] OFS_MSTP_C = 8'h10; // module_stop_ctrl_c
  localparam logic [7:0] OFS_MSTP_D = 8'h14; // module_stop_ctrl_d
  localparam logic [7:0] OFS_WAKE_EN = 8'h18; // deep_wake_enable_regs
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c; // Sticky events, read clears
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20; // Interrupt mask
  localparam logic [7:0] OFS_MODE = 8'h24; // Current mode, read only

  // Field positions
  localparam int STBY_SEL_BIT = 0; // standby_select_bit
  localparam int STBY_MAINCLK_BIT = 1; // Leave the low-speed oscillator
  localparam int DEEP_SEL_BIT = 0; // deep_standby_select_bit
  localparam int CLK_STOP_EN_BIT = 31; // all_clock_stop_enable inside module_stop_ctrl_a

  // Clock-stop match patterns
  localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
  localparam logic [31:0] MSTP_A_DONT_CARE = 32'h0000_0030; // Timer stop bits free
  localparam logic [31:0] MSTP_C_CARE = 32'hffff_0000; // Only upper half checked

  // Reset values
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [1:0] STBY_RESET = 2'h0;

  // Deep wake source layout
  localparam int WAKE_W = 25;
  localparam int WAKE_NMI = 0;
  localparam int WAKE_IRQ_LO = 1; // Sixteen external request lines
  localparam int WAKE_SCL = 17;
  localparam int WAKE_SDA = 18;
  localparam int WAKE_RX = 19;
  localparam int WAKE_RTC_ALARM = 20;
  localparam int WAKE_RTC_CYCLE = 21;
  localparam int WAKE_USB = 22;
  localparam int WAKE_LVD1 = 23;
  localparam int WAKE_LVD2 = 24;

  // Interrupt event layout
  localparam int EVT_W = 5;
  localparam int EVT_SLEEP = 0;
  localparam int EVT_ACSTOP = 1;
  localparam int EVT_SSTBY = 2;
  localparam int EVT_DSTBY = 3;
  localparam int EVT_WAKE = 4;

  // Internal reset after deep wake
  localparam int CLK_PERIOD_NS = 40;
  localparam int DEEP_RESET_NS = 1000;
  localparam int DEEP_RESET_CYC = (DEEP_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  typedef enum logic [2:0] {ST_NORMAL, ST_SLEEP, ST_ACSTOP, ST_SSTBY, ST_DSTBY, ST_DRESET} lpm_state_e;

  // Mode outputs, one bit each
  typedef struct packed {
    logic slow_osc;
    logic internal_reset;
    logic deep_standby;
    logic sw_standby;
    logic all_clock_stop;
    logic sleep;
  } mode_s;

  localparam int MODE_W = 6;

endpackage
`default_nettype wire

// ### low_power_mode_sequencer.sv
/*
  Low-power mode sequencer: picks sleep, all-module clock stop, software
  standby or deep software standby on a wait instruction and wakes on the
  sources allowed for each mode. Registers sit on an APB slave.
  Assumes wait_exec and peripheral interrupts come from pclk logic; pin
  inputs are asynchronous and are synchronised here.
  // Function
  // R01: Clock stop needs select 0, enable, A ones
  // R02: Clock stop also needs B, C-upper, D ones
  // R03: Clock stop wakes on pins, timer, peripherals
  // R04: Select 1, deep 0 enters software standby
  // R05: Software standby wakes without timer, osc-stop
  // R06: Select 1, deep 1 enters deep standby
  // R07: Deep standby wakes on dedicated pins, peripherals
  // R08: Deep wake holds fixed internal reset
  // R09: Resume normal on low-speed oscillator after deep
  // R10: Deep wake source needs its enable bit
  // R11: Otherwise wait with select 0 sleeps
  // R12: Sleep ends on any accepted interrupt
*/
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_sequencer
  import lpm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wait_exec,
  input wire logic core_irq_accept,
  input wire logic nmi_pin,
  input wire logic [15:0] irq_pin,
  input wire logic [15:0] deep_wake_ext_request,
  input wire logic deep_wake_serial_clock_pin,
  input wire logic deep_wake_serial_data_pin,
  input wire logic deep_wake_receive_pin,
  input wire logic tmr_irq,
  input wire logic rtc_alarm_irq,
  input wire logic rtc_cycle_irq,
  input wire logic independent_watchdog_irq,
  input wire logic usb_resume_irq,
  input wire logic lvd1_irq,
  input wire logic lvd2_irq,
  input wire logic osc_stop_irq,
  output mode_s mode,
  output logic irq
);

  // Pin synchronisers; stage one feeds only stage two
  logic [WAKE_W-1:0] pin_meta_q;
  logic [WAKE_W-1:0] pin_sync_q;
  logic [16:0] ext_meta_q;
  logic [16:0] ext_sync_q;

  // Registers
  logic [1:0] stby_q; // Select and main-clock bits
  logic deep_sel_q;
  logic [31:0] mstp_a_q;
  logic [31:0] mstp_b_q;
  logic [31:0] mstp_c_q;
  logic [31:0] mstp_d_q;
  logic [WAKE_W-1:0] wake_en_q;
  logic [EVT_W-1:0] stat_q;
  logic [EVT_W-1:0] mask_q;

  // Sequencer
  lpm_state_e state_q, state_d;
  logic [CNT_W-1:0] cnt_q;
  mode_s mode_d;

  // APB answer
  logic pready_q;
  logic [31:0] prdata_q;
  logic irq_q;

  localparam logic [CNT_W-1:0] RESET_LAST = CNT_W'(DEEP_RESET_CYC - 1);

  // Offset match helper, used by every decode line
  function automatic logic hit(input logic [31:0] addr, input logic [7:0] ofs);
    hit = (addr[31:8] == 24'h00_0000) && (addr[7:0] == ofs);
  endfunction

  // Pin vector in deep-wake layout; NMI is shared with normal wake
  wire [WAKE_W-1:0] pin_raw = {5'h00, deep_wake_receive_pin, deep_wake_serial_data_pin,
                               deep_wake_serial_clock_pin, deep_wake_ext_request, nmi_pin};
  wire [16:0] ext_raw = {irq_pin, nmi_pin};

  // Two-flop synchronisers for all pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      ext_meta_q <= '0;
      ext_sync_q <= '0;
    end
    else if (clk_en)
    begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
      ext_meta_q <= ext_raw;
      ext_sync_q <= ext_meta_q;
    end
  end

  // APB access completes at the edge where pready is seen high
  wire access = psel & penable & pready_q;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;

  // Address decode
  wire sel_stby = hit(paddr, OFS_STBY_CTRL);
  wire sel_deep = hit(paddr, OFS_DEEP_CTRL);
  wire sel_ma = hit(paddr, OFS_MSTP_A);
  wire sel_mb = hit(paddr, OFS_MSTP_B);
  wire sel_mc = hit(paddr, OFS_MSTP_C);
  wire sel_md = hit(paddr, OFS_MSTP_D);
  wire sel_we = hit(paddr, OFS_WAKE_EN);
  wire sel_st = hit(paddr, OFS_IRQ_STAT);
  wire sel_mk = hit(paddr, OFS_IRQ_MASK);
  wire sel_mode = hit(paddr, OFS_MODE);
  wire mapped = sel_stby | sel_deep | sel_ma | sel_mb | sel_mc | sel_md | sel_we | sel_st | sel_mk | sel_mode;

  // Read data mux, unmapped reads zero
  wire [31:0] rdata_w =
    sel_stby ? {30'h0, stby_q} :
    sel_deep ? {31'h0, deep_sel_q} :
    sel_ma ? mstp_a_q :
    sel_mb ? mstp_b_q :
    sel_mc ? mstp_c_q :
    sel_md ? mstp_d_q :
    sel_we ? {7'h00, wake_en_q} :
    sel_st ? {27'h0, stat_q} :
    sel_mk ? {27'h0, mask_q} :
    sel_mode ? {26'h0, mode} : 32'h0000_0000;

  // Clock-stop qualification
  wire clk_stop_en = mstp_a_q[CLK_STOP_EN_BIT];
  wire mstp_a_full = (mstp_a_q | MSTP_A_DONT_CARE) == ALL_ONES; // R01
  wire mstp_rest_full = (mstp_b_q == ALL_ONES) && ((mstp_c_q & MSTP_C_CARE) == MSTP_C_CARE)
                        && (mstp_d_q == ALL_ONES); // R02
  wire acstop_ok = ~stby_q[STBY_SEL_BIT] & clk_stop_en & mstp_a_full & mstp_rest_full; // R01 R02

  // Wake sources per mode
  wire ext_any = |ext_sync_q;
  wire periph_common = rtc_alarm_irq | rtc_cycle_irq | independent_watchdog_irq | usb_resume_irq
                       | lvd1_irq | lvd2_irq;
  wire wake_acstop = ext_any | periph_common | tmr_irq | osc_stop_irq; // R03
  wire wake_sstby = ext_any | periph_common; // R05
  wire [WAKE_W-1:0] deep_src = pin_sync_q
    | (WAKE_W'(rtc_alarm_irq) << WAKE_RTC_ALARM)
    | (WAKE_W'(rtc_cycle_irq) << WAKE_RTC_CYCLE)
    | (WAKE_W'(usb_resume_irq) << WAKE_USB)
    | (WAKE_W'(lvd1_irq) << WAKE_LVD1)
    | (WAKE_W'(lvd2_irq) << WAKE_LVD2); // R07
  wire wake_deep = |(deep_src & wake_en_q); // R10

  // Next-state logic
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_NORMAL:
        if (wait_exec)
        begin
          if (stby_q[STBY_SEL_BIT] && deep_sel_q)
            state_d = ST_DSTBY; // R06
          else if (stby_q[STBY_SEL_BIT])
            state_d = ST_SSTBY; // R04
          else if (acstop_ok)
            state_d = ST_ACSTOP; // R01
          else
            state_d = ST_SLEEP; // R11
        end
      ST_SLEEP:
        if (core_irq_accept)
          state_d = ST_NORMAL; // R12
      ST_ACSTOP:
        if (wake_acstop)
          state_d = ST_NORMAL; // R03
      ST_SSTBY:
        if (wake_sstby)
          state_d = ST_NORMAL; // R05
      ST_DSTBY:
        if (wake_deep)
          state_d = ST_DRESET; // R08
      ST_DRESET:
        if (cnt_q == RESET_LAST)
          state_d = ST_NORMAL; // R08
    endcase
  end

  // Mode outputs follow the next state so they leave flops in step with it
  wire leaving_reset = (state_q == ST_DRESET) && (state_d == ST_NORMAL);
  always_comb
  begin
    mode_d = '0;
    mode_d.sleep = (state_d == ST_SLEEP);
    mode_d.all_clock_stop = (state_d == ST_ACSTOP);
    mode_d.sw_standby = (state_d == ST_SSTBY);
    // Deep standby and internal reset drop on the same edge
    mode_d.deep_standby = (state_d == ST_DSTBY) || (state_d == ST_DRESET); // R08
    mode_d.internal_reset = (state_d == ST_DRESET); // R08
    // Clock source comes back to the low-speed oscillator after deep reset
    mode_d.slow_osc = (state_d == ST_DRESET) || leaving_reset || !stby_q[STBY_MAINCLK_BIT]; // R09
  end

  // Events raised on entry to sleep, clock stop and software standby, on deep reset release and on each wake
  wire entering = (state_q == ST_NORMAL) && (state_d != ST_NORMAL);
  wire [EVT_W-1:0] evt;
  assign evt[EVT_SLEEP] = entering && (state_d == ST_SLEEP);
  assign evt[EVT_ACSTOP] = entering && (state_d == ST_ACSTOP);
  assign evt[EVT_SSTBY] = entering && (state_d == ST_SSTBY);
  assign evt[EVT_DSTBY] = leaving_reset;
  assign evt[EVT_WAKE] = (state_q != ST_NORMAL) && (state_q != ST_DRESET) && (state_d != state_q)
                         || leaving_reset;

  // Read clear of status, an event in the same cycle still lands
  wire [EVT_W-1:0] stat_d = ((rd && sel_st) ? '0 : stat_q) | evt;

  // Sequencer state and reset counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_NORMAL;
      cnt_q <= '0;
      mode <= '0;
      stat_q <= '0;
      irq_q <= 1'b0;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      // Count only while the internal reset is held
      cnt_q <= (state_q == ST_DRESET) ? cnt_q + 1'b1 : '0; // R08
      mode <= mode_d;
      stat_q <= stat_d;
      irq_q <= |(stat_d & mask_q);
    end
  end

  // Software registers; deep internal reset returns them to reset values
  wire soft_reset = (state_q == ST_DRESET); // R09
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stby_q <= STBY_RESET;
      deep_sel_q <= 1'b0;
      mstp_a_q <= REG_RESET;
      mstp_b_q <= REG_RESET;
      mstp_c_q <= REG_RESET;
      mstp_d_q <= REG_RESET;
    end
    else if (clk_en)
    begin
      if (soft_reset)
      begin
        // Same state as after the reset pin
        stby_q <= STBY_RESET; // R09
        deep_sel_q <= 1'b0;
        mstp_a_q <= REG_RESET;
        mstp_b_q <= REG_RESET;
        mstp_c_q <= REG_RESET;
        mstp_d_q <= REG_RESET;
      end
      else if (wr)
      begin
        if (sel_stby)
          stby_q <= pwdata[1:0];
        if (sel_deep)
          deep_sel_q <= pwdata[DEEP_SEL_BIT];
        if (sel_ma)
          mstp_a_q <= pwdata;
        if (sel_mb)
          mstp_b_q <= pwdata;
        if (sel_mc)
          mstp_c_q <= pwdata;
        if (sel_md)
          mstp_d_q <= pwdata;
      end
    end
  end

  // Wake enables and interrupt mask survive deep standby
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_en_q <= '0;
      mask_q <= '0;
    end
    else if (clk_en && wr)
    begin
      if (sel_we)
        wake_en_q <= pwdata[WAKE_W-1:0]; // R10
      if (sel_mk)
        mask_q <= pwdata[EVT_W-1:0];
    end
  end

  // APB slave: one wait state, registered data and error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      prdata_q <= '0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready_q <= psel & penable & ~pready_q;
      if (psel && penable && !pready_q)
      begin
        prdata_q <= pwrite ? 32'h0000_0000 : rdata_w;
        // Unmapped access and writes to read-only words are flagged
        pslverr <= ~mapped | (pwrite & (sel_st | sel_mode));
      end
      else
        pslverr <= 1'b0;
    end
  end

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign irq = irq_q;

endmodule
`default_nettype wire

// ### lpm_chk.sv
/*
  Checker of the mode outputs and the APB ready pulse of the sequencer.
  Assumes it is bound to the sequencer top and sees one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module lpm_chk
  import lpm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic pready,
  input wire logic wait_exec,
  input wire logic core_irq_accept,
  input wire logic nmi_pin,
  input wire logic [15:0] irq_pin,
  input wire logic tmr_irq,
  input wire logic rtc_alarm_irq,
  input wire logic rtc_cycle_irq,
  input wire logic independent_watchdog_irq,
  input wire logic usb_resume_irq,
  input wire logic lvd1_irq,
  input wire logic lvd2_irq,
  input wire logic osc_stop_irq,
  input wire mode_s mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Sources that end software standby
  wire logic ss_src = rtc_alarm_irq | rtc_cycle_irq | independent_watchdog_irq | usb_resume_irq | lvd1_irq | lvd2_irq;
  // Clock stop also wakes on timer and oscillator stop
  wire logic ac_src = ss_src | tmr_irq | osc_stop_irq;
  wire logic pin_calm = !(nmi_pin | (|irq_pin));
  logic [2:0] calm_q; // Pin history, covers the two sync flops
  logic [7:0] cnt_q; // Length of the internal reset
  // History and length counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      calm_q <= 3'h0;
      cnt_q <= 8'h00;
    end
    else if (clk_en)
    begin
      calm_q <= {calm_q[1:0], pin_calm};
      cnt_q <= mode.internal_reset ? cnt_q + 8'h01 : 8'h00;
    end
  end
  // Reset ends with standby gone and the slow oscillator on
  sequence s_rel;
    !mode.deep_standby && mode.slow_osc && $past(mode.deep_standby);
  endsequence
  a_one_mode: assert property ($onehot0(mode[3:0])) else $error("Two modes at once");
  a_wait_enters: assert property (clk_en && wait_exec && mode[4:0] == 5'h00 |=> mode[3:0] != 4'h0)
    else $error("Wait left the block in normal mode");
  a_sleep_wake: assert property (clk_en && mode.sleep && core_irq_accept |=> !mode.sleep)
    else $error("Sleep kept after accept");
  a_acstop_wake: assert property (clk_en && mode.all_clock_stop && ac_src |=> !mode.all_clock_stop)
    else $error("Clock stop kept after source");
  a_sstby_wake: assert property (clk_en && mode.sw_standby && ss_src |=> !mode.sw_standby)
    else $error("Standby kept after source");
  a_sstby_hold: assert property (clk_en && mode.sw_standby && !ss_src && pin_calm && calm_q == 3'h7
    |=> mode.sw_standby) else $error("Standby left without source");
  a_deep_len: assert property ($fell(mode.internal_reset) |-> cnt_q == DEEP_RESET_CYC)
    else $error("Internal reset length wrong");
  a_deep_release: assert property ($fell(mode.internal_reset) |-> s_rel) else $error("Deep release wrong");
  a_reset_deep: assert property (mode.internal_reset |-> mode.deep_standby)
    else $error("Internal reset outside deep standby");
  a_ready_pulse: assert property (pready |=> !pready) else $error("Ready longer than one cycle");
endmodule
bind low_power_mode_sequencer lpm_chk u_chk (.pclk, .presetn, .clk_en, .pready, .wait_exec, .core_irq_accept,
  .nmi_pin, .irq_pin, .tmr_irq, .rtc_alarm_irq, .rtc_cycle_irq, .independent_watchdog_irq, .usb_resume_irq,
  .lvd1_irq, .lvd2_irq, .osc_stop_irq, .mode);
`default_nettype wire

// ### lpm_core_model.sv
/*
  Processor core model: issues wait instructions and accepts interrupts.
  Assumes the bench asks through do_wait and irq_req on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module lpm_core_model
  import lpm_pkg::*;
#(parameter int ACC_LAT = 1)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic do_wait,
  input wire logic irq_req,
  input wire mode_s mode,
  output logic wait_exec,
  output logic core_irq_accept
);
  logic do_wait_q; // Edge finder for the request
  logic [3:0] lat_q; // Slow acceptance, core may lag
  // One wait pulse per request; accept only while asleep
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      do_wait_q <= 1'b0;
      wait_exec <= 1'b0;
      core_irq_accept <= 1'b0;
      lat_q <= 4'h0;
    end
    else
    begin
      do_wait_q <= do_wait;
      wait_exec <= do_wait && !do_wait_q;
      lat_q <= (irq_req && mode.sleep) ? lat_q + 4'h1 : 4'h0;
      core_irq_accept <= irq_req && mode.sleep && lat_q == ACC_LAT[3:0];
    end
  end
endmodule
`default_nettype wire

// ### low_power_mode_sequencer_bench.sv
/*
  Self-checking bench of the sequencer: APB master, sources, core model.
  Assumes a 40 ns clock; clk_en stays high except for one freeze check in clock stop.
*/
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_sequencer_bench
  import lpm_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, do_wait, irq_req, nmi, pready, pslverr, irq, wait_exec, acc, err;
  logic ce; // Clock enable of the block, lowered once to prove the freeze
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [15:0] ipin;
  logic [18:0] dpin; // {rx, sda, scl, deep requests}
  logic [7:0] src; // {osc, lvd2, lvd1, usb, watchdog, rtc cycle, rtc alarm, tmr}
  mode_s mode;
  int fails, n_tests, k, n;
  low_power_mode_sequencer u_dut (.pclk, .presetn, .clk_en(ce), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .wait_exec, .core_irq_accept(acc), .nmi_pin(nmi), .irq_pin(ipin),
    .deep_wake_ext_request(dpin[15:0]), .deep_wake_serial_clock_pin(dpin[16]), .deep_wake_serial_data_pin(dpin[17]),
    .deep_wake_receive_pin(dpin[18]), .tmr_irq(src[0]), .rtc_alarm_irq(src[1]), .rtc_cycle_irq(src[2]),
    .independent_watchdog_irq(src[3]), .usb_resume_irq(src[4]), .lvd1_irq(src[5]), .lvd2_irq(src[6]),
    .osc_stop_irq(src[7]), .mode, .irq);
  // Slow core, three cycles to accept
  lpm_core_model #(.ACC_LAT(3)) u_core (.pclk, .presetn, .do_wait, .irq_req, .mode, .wait_exec,
    .core_irq_accept(acc));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task results;
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task tick(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // One APB transfer; result lands in rd and err
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    i = 0;
    do
    begin
      tick(1);
      i++;
    end
    while (pready !== 1'b1 && i < 40);
    if (pready !== 1'b1)
    begin
      fails++;
      results;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp, "read");
  endtask
  // Bounded wait for a mode value
  task want(input logic [5:0] exp, input string msg);
    int i;
    i = 0;
    while (mode !== exp && i < 60)
    begin
      tick(1);
      i++;
    end
    check({26'h0, mode}, {26'h0, exp}, msg);
    // Only a real miss ends the run; a late match must not stop it early
    if (mode !== exp)
      results;
  endtask
  task enter;
    do_wait <= 1'b1;
    tick(1);
    do_wait <= 1'b0;
  endtask
  task t_reset;
    want(6'h20, "slow clock after reset");
    rd_chk(OFS_STBY_CTRL, REG_RESET);
    apb(1'b0, 8'h28, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped");
    apb(1'b1, OFS_MODE, 32'h1);
    check({31'h0, err}, 32'h1, "read-only write");
  endtask
  task t_sleep;
    apb(1'b1, OFS_IRQ_MASK, 32'h1e);
    enter;
    want(6'h21, "sleep");
    tick(3);
    check({31'h0, irq}, 32'h0, "masked");
    apb(1'b1, OFS_IRQ_MASK, 32'h1f);
    tick(1);
    check({31'h0, irq}, 32'h1, "irq up");
    rd_chk(OFS_IRQ_STAT, 32'h1);
    tick(1);
    check({31'h0, irq}, 32'h0, "irq cleared");
    irq_req <= 1'b1;
    want(6'h20, "sleep wake");
    irq_req <= 1'b0;
    rd_chk(OFS_IRQ_STAT, 32'h10);
  endtask
  task t_acstop;
    apb(1'b1, OFS_MSTP_A, 32'hffff_ffcf);
    apb(1'b1, OFS_MSTP_B, ALL_ONES);
    apb(1'b1, OFS_MSTP_C, 32'hfffe_ffff);
    apb(1'b1, OFS_MSTP_D, ALL_ONES);
    enter;
    want(6'h21, "one stop bit short");
    irq_req <= 1'b1;
    want(6'h20, "sleep wake");
    irq_req <= 1'b0;
    apb(1'b1, OFS_MSTP_C, MSTP_C_CARE);
    for (k = 0; k < 9; k++)
    begin
      enter;
      want(6'h22, "clock stop");
      if (k == 8)
        ipin[15] <= 1'b1;
      else
        src[k] <= 1'b1;
      if (k == 1)
      begin
        // Frozen block must not see the wake source
        ce <= 1'b0;
        tick(4);
        check({26'h0, mode}, 32'h22, "frozen clock stop");
        ce <= 1'b1;
      end
      want(6'h20, "clock stop wake");
      src <= 8'h00;
      ipin <= 16'h0;
      tick(4);
    end
  endtask
  task t_sstby;
    apb(1'b1, OFS_STBY_CTRL, 32'h1);
    for (k = 0; k < 8; k++)
    begin
      enter;
      want(6'h24, "standby");
      src[k] <= 1'b1;
      tick(4);
      want((k == 0 || k == 7) ? 6'h24 : 6'h20, "standby source");
      src[k] <= 1'b0;
      // Pin wake only where the source left the block asleep
      if (k == 0 || k == 7)
      begin
        nmi <= 1'b1;
        want(6'h20, "pin wake");
        nmi <= 1'b0;
      end
      tick(4);
    end
  endtask
  task t_deep;
    apb(1'b1, OFS_DEEP_CTRL, 32'h1);
    apb(1'b1, OFS_WAKE_EN, 32'h1 << WAKE_RTC_ALARM);
    // Main clock selected, so the return to the slow oscillator is visible
    apb(1'b1, OFS_STBY_CTRL, 32'h3);
    enter;
    want(6'h08, "deep standby");
    src[4] <= 1'b1;
    dpin[0] <= 1'b1;
    tick(6);
    check({26'h0, mode}, 32'h08, "disabled sources");
    src[4] <= 1'b0;
    dpin[0] <= 1'b0;
    src[1] <= 1'b1;
    want(6'h38, "internal reset");
    src[1] <= 1'b0;
    n = 1;
    while (mode.internal_reset === 1'b1 && n < 100)
    begin
      tick(1);
      n++;
    end
    check(n - 1, DEEP_RESET_CYC, "reset length");
    check({26'h0, mode}, 32'h20, "resume");
    rd_chk(OFS_STBY_CTRL, 32'h0);
    rd_chk(OFS_WAKE_EN, 32'h1 << WAKE_RTC_ALARM);
  endtask
  // Global limit on the run
  initial
  begin
    tick(100000);
    fails++;
    results;
  end
  initial
  begin
    {psel, penable, pwrite, do_wait, irq_req, nmi} = 6'h00;
    ce = 1'b1;
    paddr = 32'h0;
    pwdata = 32'h0;
    ipin = 16'h0;
    dpin = 19'h0;
    src = 8'h00;
    fails = 0;
    n_tests = 0;
    presetn = 1'b0;
    tick(16);
    presetn <= 1'b1;
    t_reset;
    t_sleep;
    t_acstop;
    t_sstby;
    t_deep;
    results;
  end
endmodule
`default_nettype wire
